// ---- test/rtc_counter_regs_monitor.sv ----
`timescale 1ns/1ns
module rtc_counter_regs_monitor
  import rtc_counter_pkg::*;
(
  input wire logic        sys_clk,    // system clock
  input wire logic        rstn,       // async reset
  input wire logic        psel,       // apb select
  input wire logic        penable,    // apb enable
  input wire logic [5:0]  paddr,      // apb address
  input wire logic [31:0] prdata,     // apb read data
  input wire logic        pready,     // apb ready
  input wire logic        pslverr,    // apb error
  input wire logic        wrapAck,    // wrap serviced
  input wire logic        matchAck,   // match serviced
  input wire irq_req_t    wrapIrq,    // wrap request
  input wire irq_req_t    matchIrq,   // match request
  input wire logic        wrapEvent,  // wrap event
  input wire logic        matchEvent  // match event
);
  // ======
  // bus and request checks
  // ======
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_one_wait: assert property (psel && penable && !$past(penable)
    |-> !pready ##1 pready) else $error("wait state count wrong");
  a_err_decode: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0
    || paddr[5:2] inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF}))
    else $error("pslverr decode wrong");
  a_read_upper: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_wrap_vector: assert property (
    wrapIrq.req |-> wrapIrq.vector == VEC_WRAP && wrapIrq.level != 2'h0)
    else $error("wrap request fields wrong");
  a_match_vector: assert property (
    matchIrq.req |-> matchIrq.vector == VEC_MATCH && matchIrq.level != 2'h0)
    else $error("match request fields wrong");
  a_wrap_hold: assert property (
    wrapIrq.req && !wrapAck && !$past(wrapAck) && !psel && !$past(psel)
    |=> wrapIrq.req) else $error("wrap request dropped by itself");
  a_match_hold: assert property (
    matchIrq.req && !matchAck && !$past(matchAck) && !psel && !$past(psel)
    |=> matchIrq.req) else $error("match request dropped by itself");
  a_wevent_pulse: assert property (wrapEvent |=> !wrapEvent)
    else $error("wrap event longer than one cycle");
  a_mevent_pulse: assert property (matchEvent |=> !matchEvent)
    else $error("match event longer than one cycle");
endmodule : rtc_counter_regs_monitor

bind rtc_counter_regs rtc_counter_regs_monitor rtc_counter_regs_monitor_i (
  .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .wrapAck(wrapAck), .matchAck(matchAck), .wrapIrq(wrapIrq),
  .matchIrq(matchIrq), .wrapEvent(wrapEvent), .matchEvent(matchEvent));

// ---- test/rtc_counter_regs_test.sv ----
`timescale 1ns/1ns
module rtc_counter_regs_test
  import rtc_counter_pkg::*;
;
  logic        sys_clk, rstn, rtcClk, psel, penable, pwrite, pready, pslverr;
  logic        wrapAck, matchAck, wrapEvent, matchEvent, e;
  logic [5:0]  paddr;
  logic [31:0] pwdata, prdata, v;
  logic [1:0]  rtcDiv;
  irq_req_t    wrapIrq, matchIrq;
  int          cyc, wrapCnt, matchCnt, num_errors, tests_run, t0, t1, m0, r;
  int          rowC[9] = '{1, 2, 3, 4, 5, 6, 7, 1, 1};
  int          rowT[9] = '{4, 2, 2, 2, 2, 2, 2, 0, 1};
  int          divs[8] = '{0, 1, 2, 8, 16, 64, 256, 1024};
  logic [3:0]  regList[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9,
                               4'hA, 4'hB, 4'hC, 4'hD};

  rtc_counter_regs rtc_counter_regs_i (.sys_clk(sys_clk), .rstn(rstn),
    .rtcClk(rtcClk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wrapAck(wrapAck), .matchAck(matchAck),
    .wrapIrq(wrapIrq), .matchIrq(matchIrq), .wrapEvent(wrapEvent),
    .matchEvent(matchEvent));

  // ======
  // clocks and event counters
  // ======
  always #5 sys_clk = ~sys_clk;
  // real-time clock: period of six system cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    rtcDiv <= (rtcDiv == 2'h2) ? 2'h0 : rtcDiv + 2'h1;
    if (rtcDiv == 2'h2) rtcClk <= ~rtcClk;
    if (wrapEvent === 1'b1) wrapCnt <= wrapCnt + 1;
    if (matchEvent === 1'b1) matchCnt <= matchCnt + 1;
  end

  // ======
  // tasks
  // ======
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      num_errors++;
    end
  endtask : check

  task wrap_up;
    if (num_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task apb(input logic [5:0] a, input logic w, input logic [7:0] d,
           output logic [31:0] rv, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task wr(input logic [3:0] i, input logic [7:0] d);
    logic [31:0] rv;
    logic        err;
    apb({i, 2'b00}, 1'b1, d, rv, err);
  endtask : wr

  task rd(input logic [3:0] i, output logic [31:0] rv);
    logic err;
    apb({i, 2'b00}, 1'b0, 8'h00, rv, err);
  endtask : rd

  task wait_sync;
    logic [31:0] sv;
    int          n;
    n = 0;
    do begin
      rd(IDX_SYNC_STATE, sv);
      n++;
    end while (sv[0] !== 1'b0 && n < 100);
    check("sync_pending clear", sv, 32'h0);
  endtask : wait_sync

  task wait_ev(input logic m, output int t);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while ((m ? matchEvent : wrapEvent) !== 1'b1 && n < 40000);
    if (n >= 40000) begin
      num_errors++;
      wrap_up();
    end
    t = cyc;
  endtask : wait_ev

  task setup(input logic [2:0] c, input logic [7:0] t);
    wr(IDX_CTRL, 8'h00);
    wait_sync();
    wr(IDX_COUNT_LO, 8'h00);
    wr(IDX_COUNT_HI, 8'h00);
    wait_sync();
    wr(IDX_TOP_LO, t);
    wr(IDX_TOP_HI, 8'h00);
    wait_sync();
    wr(IDX_CTRL, {5'h00, c});
    wait_sync();
  endtask : setup

  // ======
  // main sequence
  // ======
  initial begin
    sys_clk = 1'b0; rstn = 1'b0; rtcClk = 1'b0; rtcDiv = 2'h0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 6'h00;
    pwdata = 32'h0; wrapAck = 1'b0; matchAck = 1'b0; cyc = 0;
    wrapCnt = 0; matchCnt = 0; num_errors = 0; tests_run = 0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    foreach (regList[k]) begin
      rd(regList[k], v);
      check("reset value", v, 32'h0);
    end
    apb(6'h14, 1'b0, 8'h00, v, e);
    check("unmapped err", {31'h0, e}, 32'h1);
    check("unmapped data", v, 32'h0);
    apb(6'h21, 1'b1, 8'hFF, v, e);
    check("misaligned err", {31'h0, e}, 32'h1);
    wr(IDX_SYNC_STATE, 8'h01);
    rd(IDX_SYNC_STATE, v);
    check("status read only", v, 32'h0);
    wr(IDX_MATCH_LO, 8'h34);
    rd(IDX_LATCH, v);
    check("latch on low write", v, 32'h34);
    wr(IDX_MATCH_HI, 8'h12);
    rd(IDX_SYNC_STATE, v);
    check("sync_pending set", v, 32'h1);
    wait_sync();
    rd(IDX_MATCH_LO, v);
    check("match low", v, 32'h34);
    rd(IDX_LATCH, v);
    check("latch on low read", v, 32'h12);
    rd(IDX_MATCH_HI, v);
    check("match high", v, 32'h12);
    wr(IDX_MATCH_LO, 8'h02);
    wr(IDX_MATCH_HI, 8'h00);
    wait_sync();
    wr(IDX_IRQ_LEVEL, 8'h09);
    rd(IDX_IRQ_LEVEL, v);
    check("levels", v, 32'h9);
    for (int k = 0; k < 9; k++) begin
      setup(rowC[k][2:0], rowT[k][7:0]);
      r = (rowT[k] == 0) ? 3 : ((rowT[k] == 1) ? 2 : 1);
      wait_ev(1'b0, t0);
      m0 = matchCnt;
      wait_ev(1'b0, t1);
      r = 6 * divs[rowC[k]] * (rowT[k] + 1) * r;
      check("wrap interval", t1 - t0, r);
      if (rowT[k] < 2) check("match above top", matchCnt - m0, 0);
    end
    setup(3'h1, 8'h04);
    wait_ev(1'b0, t0);
    wait_ev(1'b1, t1);
    check("match offset", t1 - t0, 18);
    repeat (2) @(posedge sys_clk);
    v = {21'h0, 1'b1, 2'h1, VEC_WRAP};
    check("wrap req", {21'h0, wrapIrq}, v);
    v = {21'h0, 1'b1, 2'h2, VEC_MATCH};
    check("match req", {21'h0, matchIrq}, v);
    wrapAck <= 1'b1;
    @(posedge sys_clk);
    wrapAck <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("wrap ack clears", {31'h0, wrapIrq.req}, 32'h0);
    wr(IDX_IRQ_FLAG, 8'h00);
    rd(IDX_IRQ_FLAG, v);
    check("write zero keeps flag", v & 32'h2, 32'h2);
    wr(IDX_IRQ_FLAG, 8'h02);
    repeat (2) @(posedge sys_clk);
    check("w1c clears match", {31'h0, matchIrq.req}, 32'h0);
    wait_ev(1'b1, t1);
    repeat (2) @(posedge sys_clk);
    matchAck <= 1'b1;
    @(posedge sys_clk);
    matchAck <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("match ack clears", {31'h0, matchIrq.req}, 32'h0);
    setup(3'h0, 8'h04);
    m0 = wrapCnt;
    repeat (300) @(posedge sys_clk);
    check("stopped", wrapCnt - m0, 0);
    wrap_up();
  end
endmodule : rtc_counter_regs_test

// ---- verilog/rtc_counter_pkg.sv ----
package rtc_counter_pkg;

  // ==========================================================
  // register indices; byte address is four times the index
  // ==========================================================
  localparam logic [3:0] IDX_CTRL       = 4'h0;
  localparam logic [3:0] IDX_SYNC_STATE = 4'h1;
  localparam logic [3:0] IDX_IRQ_LEVEL  = 4'h2;
  localparam logic [3:0] IDX_IRQ_FLAG   = 4'h3;
  localparam logic [3:0] IDX_LATCH      = 4'h4;
  localparam logic [3:0] IDX_COUNT_LO   = 4'h8;
  localparam logic [3:0] IDX_COUNT_HI   = 4'h9;
  localparam logic [3:0] IDX_TOP_LO     = 4'hA;
  localparam logic [3:0] IDX_TOP_HI     = 4'hB;
  localparam logic [3:0] IDX_MATCH_LO   = 4'hC;
  localparam logic [3:0] IDX_MATCH_HI   = 4'hD;

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int DIV_SEL_LSB     = 0;
  localparam int DIV_SEL_MSB     = 2;
  localparam int SYNC_PEND_BIT   = 0;
  localparam int WRAP_LVL_LSB    = 0;
  localparam int WRAP_LVL_MSB    = 1;
  localparam int MATCH_LVL_LSB   = 2;
  localparam int MATCH_LVL_MSB   = 3;
  localparam int WRAP_FLAG_BIT   = 0;
  localparam int MATCH_FLAG_BIT  = 1;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [2:0]  RST_DIV_SEL   = 3'h0;
  localparam logic [3:0]  RST_IRQ_LEVEL = 4'h0;
  localparam logic [15:0] RST_COUNT     = 16'h0000;
  localparam logic [15:0] RST_TOP       = 16'h0000;
  localparam logic [15:0] RST_MATCH     = 16'h0000;
  localparam logic [7:0]  RST_LATCH     = 8'h00;

  // ==========================================================
  // interrupt vector offsets
  // ==========================================================
  localparam logic [7:0] VEC_WRAP  = 8'h00;
  localparam logic [7:0] VEC_MATCH = 8'h02;

  // ==========================================================
  // timing: crossing latency in real-time clock cycles
  // ==========================================================
  localparam int SYNC_RTC_CYCLES = 2;

  // prescaler terminal counts, indexed by divide select code
  localparam logic [9:0] DIV_TC_1    = 10'h000;
  localparam logic [9:0] DIV_TC_2    = 10'h001;
  localparam logic [9:0] DIV_TC_8    = 10'h007;
  localparam logic [9:0] DIV_TC_16   = 10'h00F;
  localparam logic [9:0] DIV_TC_64   = 10'h03F;
  localparam logic [9:0] DIV_TC_256  = 10'h0FF;
  localparam logic [9:0] DIV_TC_1024 = 10'h3FF;

  typedef enum logic [2:0] {
    SYNC_IDLE = 3'b001,
    SYNC_ONE  = 3'b010,
    SYNC_TWO  = 3'b100
  } sync_state_t;

  // one interrupt request toward the interrupt controller
  typedef struct packed {
    logic       req;
    logic [1:0] level;
    logic [7:0] vector;
  } irq_req_t;

endpackage : rtc_counter_pkg

// ---- verilog/rtc_counter_regs.sv ----
`timescale 1ns/1ns

// Summary of operation
// - sync_pending reads high while a count/control/top/match write crosses.
// - match_irq_level bits 3:2 enable match request and set its level.
// - wrap_irq_level bits 1:0 enable wrap request and set its level.
// - match_flag (bit 1) sets on the count after count equals match.
// - match_flag clears on vector service or writing one; zero no effect.
// - wrap_flag (bit 0) sets on the count after count equals top.
// - wrap_flag clears on vector service or writing one.
// - low byte writes go to latch; low byte reads latch high byte.
// - 16-bit tick_count advances on each prescaled real-time clock edge.
// - count, top and match writes take effect two real-time cycles later.
// - count equal to top sets wrap_flag and returns count to zero.
// - count equal to match sets match_flag.
// - match above top never produces a match request or event.
// - wrap request uses vector 0x00, match request vector 0x02.
// - divide select 000 stops; 001..111 divide by 1,2,8,16,64,256,1024.
// - events every third occurrence at top 0, every second at top 1.
module rtc_counter_regs
  import rtc_counter_pkg::*;
(
  input  wire logic        sys_clk,     // system clock, 100 MHz
  input  wire logic        rstn,        // async reset, active low
  input  wire logic        rtcClk,      // real-time clock from its pin
  input  wire logic        psel,        // apb select
  input  wire logic        penable,     // apb enable
  input  wire logic        pwrite,      // apb direction
  input  wire logic [5:0]  paddr,       // apb byte address
  input  wire logic [31:0] pwdata,      // apb write data
  output logic      [31:0] prdata,      // apb read data
  output logic             pready,      // apb ready
  output logic             pslverr,     // apb error, unmapped address
  input  wire logic        wrapAck,     // wrap vector serviced
  input  wire logic        matchAck,    // match vector serviced
  output irq_req_t         wrapIrq,     // wrap interrupt request
  output irq_req_t         matchIrq,    // match interrupt request
  output logic             wrapEvent,   // wrap event pulse
  output logic             matchEvent   // match event pulse
);

  // ==========================================================
  // state
  // ==========================================================
  logic        rtcMeta;
  logic        rtcSync;
  logic        rtcLast;
  logic        rtcTick;
  logic [9:0]  preCount;
  logic [9:0]  preTc;
  logic        countEn;
  logic [2:0]  divSel;
  logic [2:0]  divShadow;
  logic [3:0]  irqLevel;
  logic        wrapFlag;
  logic        matchFlag;
  logic [7:0]  latch;
  logic [15:0] count;
  logic [15:0] top;
  logic [15:0] match;
  logic [15:0] countShadow;
  logic [15:0] topShadow;
  logic [15:0] matchShadow;
  logic        countDirty;
  logic        topDirty;
  logic        matchDirty;
  sync_state_t syncState;
  logic        syncApply;
  logic        syncPending;
  logic [1:0]  wrapEvDiv;
  logic [1:0]  matchEvDiv;
  logic [1:0]  evRatio;
  logic        hitTop;
  logic        hitMatch;
  logic        busDone;
  logic        busWr;
  logic        busRd;
  logic [3:0]  regIdx;
  logic        mapped;
  logic [7:0]  wByte;
  logic [7:0]  rByte;

  // ==========================================================
  // apb slave: one wait state, answer registered
  // ==========================================================
  assign regIdx  = paddr[5:2];
  assign busDone = psel & penable & pready;
  assign busWr   = busDone & pwrite & mapped;
  assign busRd   = busDone & ~pwrite & mapped;
  assign wByte   = pwdata[7:0];

  always_comb begin
    mapped = 1'b1;
    rByte  = 8'h00;
    case (regIdx)
      IDX_CTRL:       rByte = {5'h00, divShadow};
      IDX_SYNC_STATE: rByte = {7'h00, syncPending};
      IDX_IRQ_LEVEL:  rByte = {4'h0, irqLevel};
      IDX_IRQ_FLAG:   rByte = {6'h00, matchFlag, wrapFlag};
      IDX_LATCH:      rByte = latch;
      IDX_COUNT_LO:   rByte = count[7:0];
      IDX_COUNT_HI:   rByte = latch;
      IDX_TOP_LO:     rByte = topShadow[7:0];
      IDX_TOP_HI:     rByte = latch;
      IDX_MATCH_LO:   rByte = matchShadow[7:0];
      IDX_MATCH_HI:   rByte = latch;
      default:        mapped = 1'b0;
    endcase
    if (paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel & penable & ~pready & ~pwrite) begin
        prdata <= {24'h00_0000, rByte};
      end
    end
  end

  // ==========================================================
  // byte latch for 16-bit access
  // ==========================================================
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      latch <= RST_LATCH;
    end else if (busWr && (regIdx == IDX_LATCH ||
                           regIdx == IDX_COUNT_LO ||
                           regIdx == IDX_TOP_LO ||
                           regIdx == IDX_MATCH_LO)) begin
      latch <= wByte;
    end else if (busRd) begin
      case (regIdx)
        IDX_COUNT_LO: latch <= count[15:8];
        IDX_TOP_LO:   latch <= topShadow[15:8];
        IDX_MATCH_LO: latch <= matchShadow[15:8];
        default:      latch <= latch;
      endcase
    end
  end

  // ==========================================================
  // control and interrupt level registers
  // ==========================================================
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      divShadow <= RST_DIV_SEL;
      irqLevel  <= RST_IRQ_LEVEL;
    end else if (busWr) begin
      if (regIdx == IDX_CTRL) begin
        divShadow <= wByte[DIV_SEL_MSB:DIV_SEL_LSB];
      end
      if (regIdx == IDX_IRQ_LEVEL) begin
        irqLevel <= wByte[MATCH_LVL_MSB:WRAP_LVL_LSB];
      end
    end
  end

  // ==========================================================
  // write shadows for the crossing registers
  // ==========================================================
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      countShadow <= RST_COUNT;
      topShadow   <= RST_TOP;
      matchShadow <= RST_MATCH;
      countDirty  <= 1'b0;
      topDirty    <= 1'b0;
      matchDirty  <= 1'b0;
    end else if (busWr) begin
      case (regIdx)
        IDX_COUNT_HI: begin
          countShadow <= {wByte, latch};
          countDirty  <= 1'b1;
        end
        IDX_TOP_HI: begin
          topShadow <= {wByte, latch};
          topDirty  <= 1'b1;
        end
        IDX_MATCH_HI: begin
          matchShadow <= {wByte, latch};
          matchDirty  <= 1'b1;
        end
        default: countDirty <= countDirty;
      endcase
    end else if (syncApply) begin
      countDirty <= 1'b0;
      topDirty   <= 1'b0;
      matchDirty <= 1'b0;
    end
  end

  // ==========================================================
  // real-time clock pin synchroniser and edge detect
  // ==========================================================
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rtcMeta <= 1'b0;
      rtcSync <= 1'b0;
      rtcLast <= 1'b0;
    end else begin
      rtcMeta <= rtcClk;
      rtcSync <= rtcMeta;
      rtcLast <= rtcSync;
    end
  end

  assign rtcTick = rtcSync & ~rtcLast;

  // ==========================================================
  // crossing: new values land after two real-time clock edges
  // ==========================================================
  logic syncStart;
  assign syncStart = busWr && (regIdx == IDX_CTRL ||
                               regIdx == IDX_COUNT_HI ||
                               regIdx == IDX_TOP_HI ||
                               regIdx == IDX_MATCH_HI);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      syncState <= SYNC_IDLE;
    end else if (syncStart) begin
      syncState <= SYNC_ONE;
    end else if (rtcTick) begin
      case (syncState)
        SYNC_ONE: syncState <= SYNC_TWO;
        SYNC_TWO: syncState <= SYNC_IDLE;
        default:  syncState <= SYNC_IDLE;
      endcase
    end
  end

  assign syncApply   = rtcTick & (syncState == SYNC_TWO) & ~syncStart;
  assign syncPending = (syncState != SYNC_IDLE);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      divSel <= RST_DIV_SEL;
      top    <= RST_TOP;
      match  <= RST_MATCH;
    end else if (syncApply) begin
      divSel <= divShadow;
      if (topDirty) begin
        top <= topShadow;
      end
      if (matchDirty) begin
        match <= matchShadow;
      end
    end
  end

  // ==========================================================
  // prescaler
  // ==========================================================
  always_comb begin
    case (divSel)
      3'h1:    preTc = DIV_TC_1;
      3'h2:    preTc = DIV_TC_2;
      3'h3:    preTc = DIV_TC_8;
      3'h4:    preTc = DIV_TC_16;
      3'h5:    preTc = DIV_TC_64;
      3'h6:    preTc = DIV_TC_256;
      3'h7:    preTc = DIV_TC_1024;
      default: preTc = DIV_TC_1;
    endcase
  end

  assign countEn = rtcTick & (divSel != 3'h0) & (preCount >= preTc);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      preCount <= 10'h000;
    end else if (divSel == 3'h0) begin
      preCount <= 10'h000;
    end else if (rtcTick) begin
      preCount <= countEn ? 10'h000 : preCount + 10'h001;
    end
  end

  // ==========================================================
  // tick counter and compares
  // ==========================================================
  assign hitTop   = (count == top);
  assign hitMatch = (count == match) && (match <= top);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count <= RST_COUNT;
    end else if (syncApply && countDirty) begin
      count <= countShadow;
    end else if (countEn) begin
      count <= hitTop ? 16'h0000 : count + 16'h0001;
    end
  end

  // ==========================================================
  // flags: set wins over clear
  // ==========================================================
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wrapFlag  <= 1'b0;
      matchFlag <= 1'b0;
    end else begin
      if (countEn && hitTop) begin
        wrapFlag <= 1'b1;
      end else if (wrapAck || (busWr && regIdx == IDX_IRQ_FLAG &&
                               wByte[WRAP_FLAG_BIT])) begin
        wrapFlag <= 1'b0;
      end
      if (countEn && hitMatch) begin
        matchFlag <= 1'b1;
      end else if (matchAck || (busWr && regIdx == IDX_IRQ_FLAG &&
                                wByte[MATCH_FLAG_BIT])) begin
        matchFlag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // interrupt requests
  // ==========================================================
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wrapIrq  <= '0;
      matchIrq <= '0;
    end else begin
      wrapIrq.level  <= irqLevel[WRAP_LVL_MSB:WRAP_LVL_LSB];
      wrapIrq.req    <= wrapFlag &
                        (irqLevel[WRAP_LVL_MSB:WRAP_LVL_LSB] != 2'h0);
      wrapIrq.vector <= VEC_WRAP;
      matchIrq.level <= irqLevel[MATCH_LVL_MSB:MATCH_LVL_LSB];
      matchIrq.req   <= matchFlag &
                        (irqLevel[MATCH_LVL_MSB:MATCH_LVL_LSB] != 2'h0);
      matchIrq.vector <= VEC_MATCH;
    end
  end

  // ==========================================================
  // events, thinned when top is zero or one
  // ==========================================================
  always_comb begin
    if (top == 16'h0000) begin
      evRatio = 2'h2;
    end else if (top == 16'h0001) begin
      evRatio = 2'h1;
    end else begin
      evRatio = 2'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wrapEvDiv  <= 2'h0;
      matchEvDiv <= 2'h0;
      wrapEvent  <= 1'b0;
      matchEvent <= 1'b0;
    end else begin
      wrapEvent  <= countEn & hitTop & (wrapEvDiv >= evRatio);
      matchEvent <= countEn & hitMatch & (matchEvDiv >= evRatio);
      if (countEn && hitTop) begin
        wrapEvDiv <= (wrapEvDiv >= evRatio) ? 2'h0 : wrapEvDiv + 2'h1;
      end
      if (countEn && hitMatch) begin
        matchEvDiv <= (matchEvDiv >= evRatio) ? 2'h0 : matchEvDiv + 2'h1;
      end
    end
  end

endmodule : rtc_counter_regs
